// ### common/tas_consts.svh
// Constant codes, field positions and reset values of the alarm and sequencer register bank.
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH

// ==========================================================================
// Write codes (4 bits) and read codes (5 bits)
// ==========================================================================
`define TAS_WR_CTRL1        4'h1
`define TAS_WR_ALARM        4'h3
`define TAS_WR_AUX_ONE_HI   4'h4
`define TAS_WR_AUX_ONE_LO   4'h5
`define TAS_WR_BAT_ONE_HI   4'h6
`define TAS_WR_BAT_ONE_LO   4'h7
`define TAS_WR_BAT_TWO_HI   4'h8
`define TAS_WR_BAT_TWO_LO   4'h9
`define TAS_WR_TEMP_LO      4'ha
`define TAS_WR_TEMP_HI      4'hb
`define TAS_WR_SEQ_SLAVE    4'hc
`define TAS_WR_SEQ_MASTER   4'hd
`define TAS_WR_OUT_CONV     4'he
`define TAS_RD_CTRL1        5'h01
`define TAS_RD_ALARM        5'h03
`define TAS_RD_LIMIT_FIRST  5'h04
`define TAS_RD_LIMIT_LAST   5'h0b
`define TAS_RD_SEQ_SLAVE    5'h0c
`define TAS_RD_SEQ_MASTER   5'h0d
`define TAS_RD_OUT_CONV     5'h0e
`define TAS_RD_VERT_POS     5'h10
`define TAS_RD_HORZ_POS     5'h11
`define TAS_RD_PRESS_2      5'h12

// ==========================================================================
// Conversion channel codes and conversion kinds
// ==========================================================================
`define TAS_CH_VERT_POS     4'h0
`define TAS_CH_HORZ_POS     4'h1
`define TAS_CH_PRESS_2      4'h2
`define TAS_CH_AUX_ONE      4'h3
`define TAS_CH_BAT_ONE      4'h6
`define TAS_CH_BAT_TWO      4'h7
`define TAS_CH_THERMAL      4'h8
`define TAS_KIND_SLAVE_SEQ  2'h2
`define TAS_KIND_MASTER_SEQ 2'h3

// ==========================================================================
// Field positions, frame sizes and reset values
// ==========================================================================
`define TAS_CTRL1_KIND_LSB  0
`define TAS_CTRL1_RD_LSB    2
`define TAS_OC_SPAN_BIT     0
`define TAS_OC_CURRENT_BIT  2
`define TAS_OC_SLEEP_BIT    3
`define TAS_OC_CODE_LSB     4
`define TAS_FRAME_BITS      16
`define TAS_REG_RESET       12'h000
`define TAS_HOST_CMD_ADDR   4'h0
`define TAS_HOST_STAT_ADDR  4'h4
`define TAS_HOST_RX_ADDR    4'h8
`define TAS_HOST_HALF_DIV   4

`endif

// ### common/tas_link_if.sv
// Four-wire synchronous serial link between host and register bank.
`timescale 1ns/1ps
interface tas_link_if;
    logic cs_b;
    logic sclk;
    logic mosi;
    logic miso;

    modport dev
    (
        input  cs_b,
        input  sclk,
        input  mosi,
        output miso
    );

    modport host
    (
        output cs_b,
        output sclk,
        output mosi,
        input  miso
    );
endinterface : tas_link_if

// ### common/tas_pkg.sv
// Types shared by both ends of the serial register link.
package tas_pkg;
    typedef logic [11:0] tas_word_t;
    typedef logic [15:0] tas_frame_t;

    typedef enum logic [1:0]
    {
        TAS_HOST_IDLE  = 2'b01,
        TAS_HOST_SHIFT = 2'b10
    } tas_host_state_e;
endpackage : tas_pkg

// ### logic/tas_link_host.sv
// Host end: turns software command words into serial frames and captures the reply.
`timescale 1ns/1ps
`include "tas_consts.svh"

module tas_link_host
    import tas_pkg::*;
#(
    parameter int HALF_DIV = `TAS_HOST_HALF_DIV
)
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    tas_link_if.host        link,
    input  wire logic [3:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [15:0]     rdata_o
);

    tas_host_state_e state_ff;
    logic [7:0]  div_ff;
    logic [4:0]  half_ff;
    tas_frame_t  tx_ff;
    tas_frame_t  rx_ff;
    logic        cs_b_ff;
    logic        sclk_ff;
    logic [15:0] rdata_ff;

    wire tick      = (div_ff == 8'(HALF_DIV - 1));
    wire busy      = (state_ff == TAS_HOST_SHIFT);
    // A command written while a frame runs is dropped; software polls busy first.
    wire start     = wr_i && addr_i == `TAS_HOST_CMD_ADDR && !busy;
    wire last_half = (half_ff == 5'(2 * `TAS_FRAME_BITS - 1));

    wire [15:0] rd_mux = (addr_i == `TAS_HOST_STAT_ADDR) ? {15'h0000, busy}
                       : (addr_i == `TAS_HOST_RX_ADDR)   ? rx_ff
                       : 16'h0000;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_ff <= TAS_HOST_IDLE;
            div_ff   <= 8'h00;
            half_ff  <= 5'h00;
            tx_ff    <= 16'h0000;
            rx_ff    <= 16'h0000;
            cs_b_ff  <= 1'b1;
            sclk_ff  <= 1'b0;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            rdata_ff <= rd_i ? rd_mux : 16'h0000;
            unique case (state_ff)
                TAS_HOST_IDLE:
                begin
                    if (start)
                    begin
                        state_ff <= TAS_HOST_SHIFT;
                        tx_ff    <= wdata_i;
                        cs_b_ff  <= 1'b0;
                        div_ff   <= 8'h00;
                        half_ff  <= 5'h00;
                    end
                end
                TAS_HOST_SHIFT:
                begin
                    div_ff <= tick ? 8'h00 : div_ff + 8'h01;
                    if (tick)
                    begin
                        half_ff <= half_ff + 5'h01;
                        sclk_ff <= ~half_ff[0];
                        if (!half_ff[0])
                        begin
                            rx_ff <= {rx_ff[14:0], link.miso};
                        end
                        else
                        begin
                            tx_ff <= {tx_ff[14:0], 1'b0};
                        end
                        if (last_half)
                        begin
                            state_ff <= TAS_HOST_IDLE;
                            cs_b_ff  <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign link.cs_b = cs_b_ff;
    assign link.sclk = sclk_ff;
    assign link.mosi = tx_ff[15];
    assign rdata_o   = rdata_ff;

endmodule : tas_link_host

// ### logic/tas_regs_dev.sv
// Alarm, limit, sequencer, output converter and result register bank on the serial link.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "tas_consts.svh"

module tas_regs_dev
    import tas_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    tas_link_if.dev         link,
    input  wire logic       conv_valid_i,
    input  wire logic [3:0] conv_chan_i,
    input  wire logic [11:0] conv_data_i,
    output logic            alert_o,
    output logic [1:0]      conversion_kind_o,
    output logic [11:0]     active_picks_o,
    output logic            output_span_full_o,
    output logic            output_current_mode_o,
    output logic            output_converter_sleep_o,
    output logic [7:0]      output_code_o
);

    // ======================================================================
    // Register storage
    // ======================================================================
    tas_word_t  ctrl1_ff;
    tas_word_t  alarm_ff;
    tas_word_t  limit_ff [4:11];
    tas_word_t  seq_slave_ff;
    tas_word_t  seq_master_ff;
    tas_word_t  out_conv_ff;
    tas_word_t  vert_pos_ff;
    tas_word_t  horz_pos_ff;
    tas_word_t  press_2_ff;
    logic       alert_ff;
    logic [11:0] picks_ff;

    // ======================================================================
    // Serial frame receive and transmit
    // ======================================================================
    logic       sclk_ff;
    logic       cs_b_ff;
    logic [4:0] bit_cnt_ff;
    tas_frame_t rx_sr_ff;
    tas_frame_t tx_sr_ff;
    logic       miso_ff;

    wire        sclk_rise  = link.sclk & ~sclk_ff & ~link.cs_b;
    wire        sclk_fall  = ~link.sclk & sclk_ff & ~link.cs_b;
    wire        frame_open = ~link.cs_b & cs_b_ff;
    wire tas_frame_t rx_next = {rx_sr_ff[14:0], link.mosi};
    // The write lands on the sixteenth rising edge, so a frame cut short writes nothing.
    wire        wr_commit  = sclk_rise && (bit_cnt_ff == 5'(`TAS_FRAME_BITS - 1));
    wire [3:0]  wr_code    = rx_next[15:12];
    wire tas_word_t wr_data = rx_next[11:0];
    wire [4:0]  rd_code    = ctrl1_ff[`TAS_CTRL1_RD_LSB +: 5];

    // ======================================================================
    // Read selection, driven from the read code held in control word one
    // ======================================================================
    tas_word_t rd_data;
    always_comb
    begin
        rd_data = `TAS_REG_RESET;
        if (rd_code >= `TAS_RD_LIMIT_FIRST && rd_code <= `TAS_RD_LIMIT_LAST)
        begin
            rd_data = limit_ff[rd_code[3:0]];
        end
        else
        begin
            unique case (rd_code)
                `TAS_RD_CTRL1:      rd_data = ctrl1_ff;
                `TAS_RD_ALARM:      rd_data = alarm_ff;
                `TAS_RD_SEQ_SLAVE:  rd_data = seq_slave_ff;
                `TAS_RD_SEQ_MASTER: rd_data = seq_master_ff;
                `TAS_RD_OUT_CONV:   rd_data = out_conv_ff;
                `TAS_RD_VERT_POS:   rd_data = vert_pos_ff;
                `TAS_RD_HORZ_POS:   rd_data = horz_pos_ff;
                `TAS_RD_PRESS_2:    rd_data = press_2_ff;
                default:            rd_data = `TAS_REG_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_ff    <= 1'b0;
            cs_b_ff    <= 1'b1;
            bit_cnt_ff <= 5'h00;
            rx_sr_ff   <= 16'h0000;
            tx_sr_ff   <= 16'h0000;
            miso_ff    <= 1'b0;
        end
        else
        begin
            sclk_ff <= link.sclk;
            cs_b_ff <= link.cs_b;
            if (link.cs_b)
            begin
                bit_cnt_ff <= 5'h00;
            end
            else if (sclk_rise)
            begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                rx_sr_ff   <= rx_next;
            end
            // The register chosen by the last read code goes out during the next frame.
            if (frame_open)
            begin
                tx_sr_ff <= {4'h0, rd_data};
                miso_ff  <= 1'b0;
            end
            else if (sclk_fall)
            begin
                tx_sr_ff <= {tx_sr_ff[14:0], 1'b0};
                miso_ff  <= tx_sr_ff[14];
            end
        end
    end

    assign link.miso = miso_ff;

    // ======================================================================
    // Limit comparison on auxiliary, battery and temperature conversion results
    // ======================================================================
    wire is_aux_one = conv_valid_i && conv_chan_i == `TAS_CH_AUX_ONE;
    wire is_bat_one = conv_valid_i && conv_chan_i == `TAS_CH_BAT_ONE;
    wire is_bat_two = conv_valid_i && conv_chan_i == `TAS_CH_BAT_TWO;
    wire is_temp    = conv_valid_i && conv_chan_i == `TAS_CH_THERMAL;

    wire [7:0] flag_set;
    assign flag_set[0] = is_aux_one && conv_data_i < limit_ff[`TAS_WR_AUX_ONE_LO];
    assign flag_set[1] = is_bat_one && conv_data_i < limit_ff[`TAS_WR_BAT_ONE_LO];
    assign flag_set[2] = is_bat_two && conv_data_i < limit_ff[`TAS_WR_BAT_TWO_LO];
    assign flag_set[3] = is_temp    && conv_data_i > limit_ff[`TAS_WR_TEMP_HI];
    assign flag_set[4] = is_aux_one && conv_data_i > limit_ff[`TAS_WR_AUX_ONE_HI];
    assign flag_set[5] = is_bat_one && conv_data_i > limit_ff[`TAS_WR_BAT_ONE_HI];
    assign flag_set[6] = is_bat_two && conv_data_i > limit_ff[`TAS_WR_BAT_TWO_HI];
    assign flag_set[7] = is_temp    && conv_data_i < limit_ff[`TAS_WR_TEMP_LO];

    // A software clear and a hardware set in one cycle leave the flag set.
    wire tas_word_t alarm_base = (wr_commit && wr_code == `TAS_WR_ALARM) ? wr_data : alarm_ff;
    wire tas_word_t nxt_alarm  = alarm_base | {4'h0, flag_set};
    // Both flags of one channel share a column, so one enable bit gates both.
    wire [3:0]  chan_flags = nxt_alarm[3:0] | nxt_alarm[7:4];
    wire        nxt_alert  = |(chan_flags & nxt_alarm[11:8]);

    wire [1:0]  nxt_kind   = (wr_commit && wr_code == `TAS_WR_CTRL1)
                             ? wr_data[`TAS_CTRL1_KIND_LSB +: 2] : ctrl1_ff[1:0];
    wire tas_word_t nxt_slave  = (wr_commit && wr_code == `TAS_WR_SEQ_SLAVE)
                                 ? wr_data : seq_slave_ff;
    wire tas_word_t nxt_master = (wr_commit && wr_code == `TAS_WR_SEQ_MASTER)
                                 ? wr_data : seq_master_ff;
    // Bit 0 of both sequence words picks nothing and is kept off the outputs.
    wire [11:0] nxt_picks  = (nxt_kind == `TAS_KIND_SLAVE_SEQ)  ? {nxt_slave[11:1], 1'b0}
                           : (nxt_kind == `TAS_KIND_MASTER_SEQ) ? {nxt_master[11:1], 1'b0}
                           : 12'h000;

    // ======================================================================
    // Register writes and result capture
    // ======================================================================
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl1_ff      <= `TAS_REG_RESET;
            alarm_ff      <= `TAS_REG_RESET;
            seq_slave_ff  <= `TAS_REG_RESET;
            seq_master_ff <= `TAS_REG_RESET;
            out_conv_ff   <= `TAS_REG_RESET;
            alert_ff      <= 1'b0;
            picks_ff      <= 12'h000;
        end
        else
        begin
            alarm_ff      <= nxt_alarm;
            alert_ff      <= nxt_alert;
            seq_slave_ff  <= nxt_slave;
            seq_master_ff <= nxt_master;
            picks_ff      <= nxt_picks;
            if (wr_commit && wr_code == `TAS_WR_CTRL1)
            begin
                ctrl1_ff <= wr_data;
            end
            if (wr_commit && wr_code == `TAS_WR_OUT_CONV)
            begin
                out_conv_ff <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 4; i <= 11; i++)
            begin
                limit_ff[i] <= `TAS_REG_RESET;
            end
        end
        else if (wr_commit && wr_code >= `TAS_WR_AUX_ONE_HI && wr_code <= `TAS_WR_TEMP_HI)
        begin
            limit_ff[wr_code] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            vert_pos_ff <= `TAS_REG_RESET;
            horz_pos_ff <= `TAS_REG_RESET;
            press_2_ff  <= `TAS_REG_RESET;
        end
        else if (conv_valid_i)
        begin
            if (conv_chan_i == `TAS_CH_VERT_POS)
            begin
                vert_pos_ff <= conv_data_i;
            end
            if (conv_chan_i == `TAS_CH_HORZ_POS)
            begin
                horz_pos_ff <= conv_data_i;
            end
            if (conv_chan_i == `TAS_CH_PRESS_2)
            begin
                press_2_ff <= conv_data_i;
            end
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign alert_o                  = alert_ff;
    assign conversion_kind_o        = ctrl1_ff[`TAS_CTRL1_KIND_LSB +: 2];
    assign active_picks_o           = picks_ff;
    assign output_span_full_o       = out_conv_ff[`TAS_OC_SPAN_BIT];
    assign output_current_mode_o    = out_conv_ff[`TAS_OC_CURRENT_BIT];
    assign output_converter_sleep_o = out_conv_ff[`TAS_OC_SLEEP_BIT];
    assign output_code_o            = out_conv_ff[`TAS_OC_CODE_LSB +: 8];

endmodule : tas_regs_dev

// ### test/tas_link_asserts.sv
// Protocol checker for the four-wire link between host end and register bank.
`timescale 1ns/1ps
// ========================================
// Link checker
// ========================================
module tas_link_asserts
#(
    parameter int HALF_DIV = 2
)
(
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic cs_b,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso
);
    // The frame length is bounded loosely; the rise count pins the exact framing.
    localparam int FRAME_MIN = 32 * HALF_DIV - 2;
    localparam int FRAME_MAX = 32 * HALF_DIV + 2;

    logic       sclk_q_ff;
    logic [4:0] rise_cnt_ff;
    logic [4:0] nxt_rise_cnt;
    wire        sclk_rise;

    assign sclk_rise    = sclk & ~sclk_q_ff;
    assign nxt_rise_cnt = cs_b ? 5'h00 : rise_cnt_ff + {4'h0, sclk_rise};

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_q_ff   <= 1'b0;
            rise_cnt_ff <= 5'h00;
        end
        else
        begin
            sclk_q_ff   <= sclk;
            rise_cnt_ff <= nxt_rise_cnt;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // The clock widths below assume the bench runs with a HALF_DIV of 2.
    sequence s_clock_high;
        sclk [*2] ##1 !sclk;
    endsequence

    property p_idle_clock_low;
        cs_b |-> !sclk;
    endproperty
    property p_sixteen_rises;
        $rose(cs_b) |-> rise_cnt_ff == 5'h10;
    endproperty
    property p_reply_lead_zero;
        !cs_b && sclk_rise && rise_cnt_ff < 5'h04 |-> !miso;
    endproperty
    property p_mosi_steady;
        sclk |-> $stable(mosi);
    endproperty
    property p_clock_high_width;
        $rose(sclk) |-> s_clock_high;
    endproperty
    property p_clock_low_width;
        $fell(sclk) |-> !sclk [*2];
    endproperty
    property p_frame_length;
        $fell(cs_b) |-> ##[FRAME_MIN:FRAME_MAX] $rose(cs_b);
    endproperty
    property p_select_setup;
        $fell(cs_b) |-> !sclk ##1 !sclk;
    endproperty
    property p_reset_idle;
        $rose(rst_b_i) |-> cs_b && !sclk;
    endproperty

    a_idle_clock_low: assert property (p_idle_clock_low)
        else $error("serial clock high outside a frame");
    a_sixteen_rises: assert property (p_sixteen_rises)
        else $error("frame did not carry sixteen clock rises");
    a_reply_lead_zero: assert property (p_reply_lead_zero)
        else $error("reply word lead bits not zero");
    a_mosi_steady: assert property (p_mosi_steady)
        else $error("host data moved while serial clock high");
    a_clock_high_width: assert property (p_clock_high_width)
        else $error("serial clock high phase wrong length");
    a_clock_low_width: assert property (p_clock_low_width)
        else $error("serial clock low phase too short");
    a_frame_length: assert property (p_frame_length)
        else $error("frame select length out of bounds");
    a_select_setup: assert property (p_select_setup)
        else $error("serial clock rose too soon after select");
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle after reset");
endmodule : tas_link_asserts

// ### test/touch_adc_alert_sequencer_regs_tb_top.sv
// Self-checking bench joining the host end and the register bank over the serial link.
`timescale 1ns/1ps
`include "tas_consts.svh"
// ========================================
// Bench top
// ========================================
module touch_adc_alert_sequencer_regs_tb_top
    import tas_pkg::*;
;
    logic        sys_clk_i  = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic [3:0]  addr       = 4'h0;
    tas_frame_t  wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    tas_frame_t  rdata;
    logic        valid      = 1'b0;
    logic [3:0]  chan       = 4'h0;
    tas_word_t   cdata      = 12'h000;
    logic        alert;
    logic [1:0]  kind;
    logic [11:0] picks;
    logic        span_full;
    logic        cur_mode;
    logic        conv_sleep;
    logic [7:0]  out_code;
    tas_frame_t  cap        = 16'h0000;
    logic        sclk_q     = 1'b0;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles     = 0;
    int          mreg[32];
    int          lims[4][2] = '{'{5, 4}, '{7, 6}, '{9, 8}, '{10, 11}};
    logic [3:0]  chs[4]     = '{4'h3, 4'h6, 4'h7, 4'h8};

    always #10 sys_clk_i = ~sys_clk_i;

    tas_link_if link ();
    tas_link_host #(.HALF_DIV(2)) u_tas_link_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    tas_regs_dev u_tas_regs_dev (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link),
        .conv_valid_i(valid), .conv_chan_i(chan), .conv_data_i(cdata), .alert_o(alert),
        .conversion_kind_o(kind), .active_picks_o(picks), .output_span_full_o(span_full),
        .output_current_mode_o(cur_mode), .output_converter_sleep_o(conv_sleep),
        .output_code_o(out_code));
    tas_link_asserts #(.HALF_DIV(2)) u_tas_link_asserts (.sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i), .cs_b(link.cs_b), .sclk(link.sclk), .mosi(link.mosi),
        .miso(link.miso));

    // ========================================
    // Wire capture and hang guard
    // ========================================
    always @(posedge sys_clk_i)
    begin
        sclk_q <= link.sclk;
        if (!link.cs_b && link.sclk && !sclk_q)
            cap <= {cap[14:0], link.mosi};
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            fail_count++;
            summarize();
        end
    end

    // ========================================
    // Tasks
    // ========================================
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic chk_pins();
        int a;
        int k;
        int p;
        int o;
        a = mreg[3];
        k = mreg[1] & 32'h3;
        p = (k == 2) ? mreg[12] : (k == 3) ? mreg[13] : 0;
        o = mreg[14];
        cmp({6'h00, alert, kind, picks, span_full, cur_mode, conv_sleep, out_code},
            {6'h00, |((a >> 8) & (a | a >> 4) & 32'hf), k[1:0], p[11:1], 1'b0,
             o[0], o[2], o[3], o[11:4]});
    endtask : chk_pins

    task automatic wr_cmd(input logic [3:0] a, input tas_frame_t d);
        @(posedge sys_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk_i);
        wr    <= 1'b0;
    endtask : wr_cmd

    task automatic rd_reg(input logic [3:0] a, output tas_frame_t q);
        @(posedge sys_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_i);
        rd   <= 1'b0;
        #1;
        q = rdata;
    endtask : rd_reg

    task automatic frame(input logic [3:0] wc, input logic [11:0] d);
        tas_frame_t s;
        int         n;
        wr_cmd(`TAS_HOST_CMD_ADDR, {wc, d});
        n = 0;
        s = 16'h0001;
        while (s[0] === 1'b1 && n < 200)
        begin
            rd_reg(`TAS_HOST_STAT_ADDR, s);
            n++;
        end
        // A frame that never ends is counted as a mismatch rather than hidden.
        if (s[0] !== 1'b0)
            fail_count++;
        if (wc == 4'h1 || (wc >= 4'h3 && wc <= 4'he))
            mreg[wc] = d;
        cmp({16'h0000, cap}, {16'h0000, wc, d});
        chk_pins();
    endtask : frame

    task automatic rreg(input int rc);
        tas_frame_t q;
        int         e;
        frame(4'h1, {5'h00, 5'(rc), 2'($urandom)});
        frame(4'h0, 12'($urandom));
        rd_reg(`TAS_HOST_RX_ADDR, q);
        e = (rc == 1 || (rc >= 3 && rc <= 14) || (rc >= 16 && rc <= 18)) ? mreg[rc] : 0;
        cmp({16'h0000, q}, 32'(e));
    endtask : rreg

    // Flag setting is strict: a result equal to a limit raises nothing.
    task automatic conv(input logic [3:0] c, input logic [11:0] v);
        int i;
        @(posedge sys_clk_i);
        valid <= 1'b1;
        chan  <= c;
        cdata <= v;
        @(posedge sys_clk_i);
        valid <= 1'b0;
        i = (c == 4'h3) ? 0 : (c == 4'h6) ? 1 : (c == 4'h7) ? 2 : (c == 4'h8) ? 3 : -1;
        if (c <= 4'h2)
            mreg[16 + c] = v;
        if (i >= 0 && i < 3 && v < mreg[5 + 2 * i])
            mreg[3] = mreg[3] | (1 << i);
        if (i >= 0 && i < 3 && v > mreg[4 + 2 * i])
            mreg[3] = mreg[3] | (16 << i);
        if (i == 3 && v < mreg[10])
            mreg[3] = mreg[3] | 32'h80;
        if (i == 3 && v > mreg[11])
            mreg[3] = mreg[3] | 32'h08;
        #1;
        chk_pins();
    endtask : conv

    // ========================================
    // Main sequence
    // ========================================
    initial
    begin
        void'($urandom(29322));
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk_pins();
        for (int r = 0; r < 32; r++)
            rreg(r);
        for (int w = 0; w < 16; w++)
            frame(w[3:0], 12'($urandom));
        for (int r = 0; r < 32; r++)
            rreg(r);
        for (int i = 0; i < 4; i++)
        begin
            frame(4'h3, {4'(1 << i), 8'h00});
            conv(chs[i], 12'(mreg[lims[i][0]]));
            conv(chs[i], 12'(mreg[lims[i][1]]));
            conv(chs[i], 12'(mreg[lims[i][0]] - 1));
            conv(chs[i], 12'(mreg[lims[i][1]] + 1));
            conv(chs[(i + 1) % 4], 12'($urandom));
            rreg(3);
        end
        frame(4'h3, 12'hf00);
        repeat (40)
            conv(4'($urandom), 12'($urandom));
        for (int r = 16; r < 19; r++)
            rreg(r);
        rreg(3);
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        foreach (mreg[j])
            mreg[j] = 0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk_pins();
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rreg(14);
        rreg(3);
        summarize();
    end
endmodule : touch_adc_alert_sequencer_regs_tb_top
